// ===== shared/pof_map.vh
// register offsets, field positions, reset values and the power mask of the pixel output formatter
`ifndef POF_MAP_VH
`define POF_MAP_VH
// byte addresses (index times four); printed offsets are not word aligned
`define POF_IDX_FMT 8'h18
`define POF_IDX_HSW 8'h19
`define POF_IDX_DIS 8'h1A
`define POF_IDX_PWR 8'h1B
`define POF_IDX_PLL 8'h1C
`define POF_ADR_FMT 8'h60
`define POF_ADR_HSW 8'h64
`define POF_ADR_DIS 8'h68
`define POF_ADR_PWR 8'h6C
`define POF_ADR_PLL 8'h70
// reset values
`define POF_RST_FMT 8'h00
`define POF_RST_HSW 8'h10
`define POF_RST_DIS 8'h00
`define POF_RST_PWR 8'h00
`define POF_RST_PLL 8'h49
// output format fields
`define POF_FMT_WIDE 0
`define POF_FMT_ILV 1
`define POF_FMT_SWAP 2
`define POF_FMT_UVORD 3
`define POF_FMT_422 4
`define POF_FMT_CKPOL 5
`define POF_FMT_VSPOL 6
`define POF_FMT_HSPOL 7
// disable fields
`define POF_DIS_RP 0
`define POF_DIS_RS 1
`define POF_DIS_GP 2
`define POF_DIS_GS 3
`define POF_DIS_BP 4
`define POF_DIS_BS 5
`define POF_DIS_CK 6
`define POF_DIS_CK2 7
// power fields
`define POF_PWR_R 0
`define POF_PWR_G 1
`define POF_PWR_B 2
`define POF_PWR_PLL 3
`define POF_PWR_MASK 8'h0F
`endif

// ===== verilog/pof_skid.v
// two-entry buffer between pixel source and output formatter
`timescale 1ns/1ps
module pof_skid #(
    parameter W = 26
) (
    input wire clk_i,
    input wire rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:1];
    reg wp;
    reg rp;
    reg [1:0] cnt;
    wire push = in_valid_i && (cnt != 2'd2);
    wire pop = out_ready_i && (cnt != 2'd0);
    assign in_ready_o = (cnt != 2'd2);
    assign out_valid_o = (cnt != 2'd0);
    assign out_data_o = mem[rp];
    // pointers and occupancy; full stalls the source
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wp <= ~wp;
            end
            if (pop)
            begin
                rp <= ~rp;
            end
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end
    end
    // storage has no reset, valid bookkeeping covers it
    always @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wp] <= in_data_i;
        end
    end
endmodule

// ===== verilog/pof_top.v
// pixel output formatter: register file, pixel path and pin drivers
`timescale 1ns/1ps
`include "pof_map.vh"
module pof_top (
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // pixel source, same clock domain
    input wire pix_valid_i,
    output wire pix_ready_o,
    input wire [7:0] pix_r_i,
    input wire [7:0] pix_g_i,
    input wire [7:0] pix_b_i,
    input wire pix_hs_i,
    input wire pix_vs_i,
    // pixel clock from the PLL, sampled here
    input wire pll_clk_i,
    // pins; an enable low means the pin is driven
    output reg [7:0] rp_o,
    output reg [7:0] gp_o,
    output reg [7:0] bp_o,
    output reg [7:0] rs_o,
    output reg [7:0] gs_o,
    output reg [7:0] bs_o,
    output reg [5:0] byte_oe_n_o,
    output reg pixel_output_clock_o,
    output reg clk_oe_n_o,
    output reg line_sync_output_o,
    output reg frame_sync_output_o,
    output reg [2:0] adc_pd_o,
    output reg pll_pd_o,
    output reg [7:0] pll_tune_o
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg [7:0] fmt;
    reg [7:0] hsw;
    reg [7:0] dis;
    reg [7:0] pwr;
    reg [7:0] pll;
    wire wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

    // decode used by read and write paths
    function [2:0] reg_sel;
        input [7:0] a;
        begin
            case (a)
                `POF_ADR_FMT: reg_sel = 3'd1;
                `POF_ADR_HSW: reg_sel = 3'd2;
                `POF_ADR_DIS: reg_sel = 3'd3;
                `POF_ADR_PWR: reg_sel = 3'd4;
                `POF_ADR_PLL: reg_sel = 3'd5;
                default: reg_sel = 3'd0;
            endcase
        end
    endfunction

    // one-wait-state slave; writes land at the ack edge's predecessor
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fmt <= `POF_RST_FMT;
            hsw <= `POF_RST_HSW;
            dis <= `POF_RST_DIS;
            pwr <= `POF_RST_PWR;
            pll <= `POF_RST_PLL;
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (wr_stb)
            begin
                case (reg_sel(adr_i))
                    3'd1: fmt <= dat_i[7:0];
                    3'd2: hsw <= dat_i[7:0];
                    3'd3: dis <= dat_i[7:0];
                    3'd4: pwr <= dat_i[7:0] & `POF_PWR_MASK; // reserved bits stay zero
                    3'd5: pll <= dat_i[7:0];
                    default: ;
                endcase
            end
            // unmapped reads return zero, still acknowledged
            case (reg_sel(adr_i))
                3'd1: dat_o <= {24'h000000, fmt};
                3'd2: dat_o <= {24'h000000, hsw};
                3'd3: dat_o <= {24'h000000, dis};
                3'd4: dat_o <= {24'h000000, pwr};
                3'd5: dat_o <= {24'h000000, pll};
                default: dat_o <= 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // power and pll controls
    // ---------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            adc_pd_o <= 3'b000;
            pll_pd_o <= 1'b0;
            pll_tune_o <= `POF_RST_PLL;
        end
        else
        begin
            adc_pd_o <= {pwr[`POF_PWR_B], pwr[`POF_PWR_G], pwr[`POF_PWR_R]};
            pll_pd_o <= pwr[`POF_PWR_PLL];
            pll_tune_o <= pll;
        end
    end

    // ---------------------------------------------------------------
    // pixel clock sampling
    // ---------------------------------------------------------------
    reg ck_s1;
    reg ck_s2;
    reg ck_s3;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
        end
        else
        begin
            ck_s1 <= pll_clk_i;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
        end
    end
    wire ck_rise = ck_s2 && !ck_s3;
    wire ck_fall = !ck_s2 && ck_s3;
    // launch edge and its opposite chosen by clock polarity
    wire edge_main = fmt[`POF_FMT_CKPOL] ? ck_rise : ck_fall;
    wire edge_opp = fmt[`POF_FMT_CKPOL] ? ck_fall : ck_rise;

    // ---------------------------------------------------------------
    // input buffer
    // ---------------------------------------------------------------
    wire bf_valid;
    wire [25:0] bf_data;
    wire take;
    pof_skid #(
        .W(26)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(pix_valid_i),
        .in_ready_o(pix_ready_o),
        .in_data_i({pix_vs_i, pix_hs_i, pix_r_i, pix_g_i, pix_b_i}),
        .out_valid_o(bf_valid),
        .out_ready_i(take),
        .out_data_o(bf_data)
    );
    wire [7:0] in_r = bf_data[23:16];
    wire [7:0] in_g = bf_data[15:8];
    wire [7:0] in_b = bf_data[7:0];
    wire in_hs = bf_data[24];
    wire in_vs = bf_data[25];
    wire wide = fmt[`POF_FMT_WIDE];
    // one pixel per output edge; both modes stall until an edge comes
    assign take = bf_valid && edge_main;

    // ---------------------------------------------------------------
    // pixel formatting
    // ---------------------------------------------------------------
    reg phase; // 0: even pixel after line sync, 1: odd
    reg [7:0] held_v; // chroma kept for order-clear pairing
    reg [7:0] hs_cnt;
    reg hs_act;
    reg hs_prev;
    reg [23:0] slot_a;
    reg [23:0] slot_b;
    reg [23:0] pend_s; // secondary word holder, never loaded; only reset clears it
    reg pend_en;
    reg [23:0] cur;

    // 4:2:2 conversion: luma on green, chroma on red, blue low
    always @*
    begin
        cur = {in_r, in_g, in_b};
        if (fmt[`POF_FMT_422])
        begin
            if (!phase)
            begin
                cur = {in_b, in_g, 8'h00}; // U on even pixels
            end
            else
            begin
                cur = {(fmt[`POF_FMT_UVORD] ? in_r : held_v), in_g, 8'h00};
            end
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase <= 1'b0;
            held_v <= 8'h00;
            hs_cnt <= 8'h00;
            hs_act <= 1'b0;
            hs_prev <= 1'b0;
            slot_a <= 24'h000000;
            slot_b <= 24'h000000;
            pend_s <= 24'h000000;
            pend_en <= 1'b0;
            line_sync_output_o <= 1'b0;
            frame_sync_output_o <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                hs_prev <= in_hs;
                // line sync of programmed width starts on a source sync edge
                if (in_hs && !hs_prev)
                begin
                    hs_act <= (hsw != 8'h00);
                    hs_cnt <= hsw;
                    phase <= 1'b0;
                end
                else
                begin
                    if (hs_act)
                    begin
                        if (hs_cnt <= 8'h01)
                        begin
                            hs_act <= 1'b0;
                            phase <= 1'b0; // first pixel after trailing edge
                        end
                        hs_cnt <= hs_cnt - 8'h01;
                    end
                    if (!(hs_act && hs_cnt <= 8'h01))
                    begin
                        phase <= ~phase;
                    end
                end
                if (!phase)
                begin
                    held_v <= in_r; // V of the even pixel
                end
                line_sync_output_o <= hs_act ^ fmt[`POF_FMT_HSPOL];
                frame_sync_output_o <= in_vs ^ fmt[`POF_FMT_VSPOL];
                // 48-bit: phase picks the bus, swap reverses it
                if (!wide || (phase == fmt[`POF_FMT_SWAP]))
                begin
                    slot_a <= cur;
                end
                else
                begin
                    slot_b <= cur;
                end
            end
            pend_en <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // pin drivers
    // ---------------------------------------------------------------
    wire launch_s = fmt[`POF_FMT_ILV] ? edge_opp : edge_main;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rp_o <= 8'h00;
            gp_o <= 8'h00;
            bp_o <= 8'h00;
            rs_o <= 8'h00;
            gs_o <= 8'h00;
            bs_o <= 8'h00;
            byte_oe_n_o <= 6'b000000;
            clk_oe_n_o <= 1'b0;
            pixel_output_clock_o <= 1'b0;
        end
        else
        begin
            pixel_output_clock_o <= ck_s2;
            if (edge_main)
            begin
                {rp_o, gp_o, bp_o} <= slot_a;
            end
            // secondaries low in 24-bit mode
            if (!wide)
            begin
                {rs_o, gs_o, bs_o} <= 24'h000000;
            end
            else if (launch_s)
            begin
                {rs_o, gs_o, bs_o} <= slot_b;
            end
            // enables depend only on disable bits, nothing overrides them
            byte_oe_n_o <= {dis[`POF_DIS_BS], dis[`POF_DIS_BP], dis[`POF_DIS_GS],
                            dis[`POF_DIS_GP], dis[`POF_DIS_RS], dis[`POF_DIS_RP]};
            clk_oe_n_o <= dis[`POF_DIS_CK] | dis[`POF_DIS_CK2];
        end
    end
endmodule

// ===== test/pof_top_monitor.sv
// concurrent checks on the pixel output formatter ports
`timescale 1ns/1ps
`include "pof_map.vh"
module pof_top_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire ack_o,
    input wire [7:0] bp_o,
    input wire [7:0] rs_o,
    input wire [7:0] gs_o,
    input wire [7:0] bs_o,
    input wire [5:0] byte_oe_n_o,
    input wire pixel_output_clock_o,
    input wire clk_oe_n_o,
    input wire line_sync_output_o,
    input wire [2:0] adc_pd_o,
    input wire pll_pd_o,
    input wire [7:0] pll_tune_o
);
    // shadows of written registers; quiet counts cycles since the last format write,
    // long enough for every pixel already in flight to leave the pins
    reg [7:0] fmt;
    reg [7:0] dis;
    reg [3:0] pwr;
    reg [6:0] quiet;
    wire wr = ack_o && we_i && sel_i[0];
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fmt <= 8'h00;
            dis <= 8'h00;
            pwr <= 4'h0;
            quiet <= 7'h00;
        end
        else
        begin
            if (wr && adr_i == `POF_ADR_FMT)
                fmt <= dat_i[7:0];
            if (wr && adr_i == `POF_ADR_DIS)
                dis <= dat_i[7:0];
            if (wr && adr_i == `POF_ADR_PWR)
                pwr <= dat_i[3:0];
            if (wr && adr_i == `POF_ADR_FMT)
                quiet <= 7'h00;
            else
                quiet <= quiet + {6'h00, quiet != 7'h7F};
        end
    end
    rst_defaults_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> pll_tune_o == `POF_RST_PLL && adc_pd_o == 3'h0 && !pll_pd_o
        && byte_oe_n_o == 6'h00 && !clk_oe_n_o) else $error("reset values wrong");
    power_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(wr && adr_i == `POF_ADR_PWR, 2) |-> {pll_pd_o, adc_pd_o} == pwr)
        else $error("power down outputs wrong");
    float_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(wr && adr_i == `POF_ADR_DIS, 2) |-> byte_oe_n_o == dis[5:0]
        && clk_oe_n_o == |dis[7:6]) else $error("output enables wrong");
    narrow_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet == 7'h7F && !fmt[0] |-> {rs_o, gs_o, bs_o} == 24'h000000)
        else $error("secondary bus not low");
    blue_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet == 7'h7F && fmt[4] |-> bp_o == 8'h00) else $error("blue not low");
    launch_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet == 7'h7F && $changed(bp_o) |-> pixel_output_clock_o == fmt[5])
        else $error("pixel data on wrong edge");
    sync_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet == 7'h7F && $changed(line_sync_output_o) |-> pixel_output_clock_o == fmt[5])
        else $error("line sync on wrong edge");
    second_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet == 7'h7F && fmt[0] && $changed(bs_o) |-> pixel_output_clock_o == (fmt[5] ^ fmt[1]))
        else $error("secondary data on wrong edge");
endmodule
bind pof_top pof_top_monitor MON (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .bp_o(bp_o), .rs_o(rs_o), .gs_o(gs_o),
    .bs_o(bs_o), .byte_oe_n_o(byte_oe_n_o), .pixel_output_clock_o(pixel_output_clock_o),
    .clk_oe_n_o(clk_oe_n_o), .line_sync_output_o(line_sync_output_o), .adc_pd_o(adc_pd_o),
    .pll_pd_o(pll_pd_o), .pll_tune_o(pll_tune_o));

// ===== test/pof_rx.sv
// downstream receiver: floated bytes read low through pull-downs, capture on far edges
`timescale 1ns/1ps
module pof_rx (
    input wire clk_i,
    input wire [47:0] pins_i,
    input wire [5:0] oe_n_i,
    input wire pclk_i,
    input wire [1:0] edge_i,
    output reg [23:0] pri_o,
    output reg [23:0] sec_o,
    output reg pri_ev_o,
    output reg sec_ev_o
);
    // enable order is rp,rs,gp,gs,bp,bs; pins arrive as {rp,gp,bp,rs,gs,bs}
    wire [47:0] lvl = pins_i & {{8{!oe_n_i[0]}}, {8{!oe_n_i[2]}}, {8{!oe_n_i[4]}},
        {8{!oe_n_i[1]}}, {8{!oe_n_i[3]}}, {8{!oe_n_i[5]}}};
    reg pc_q = 1'b0;
    // sample mid-period, on the edge away from the one that launches each bus
    always @(posedge clk_i)
    begin
        pc_q <= pclk_i;
        pri_ev_o <= (pclk_i != pc_q) && (pclk_i != edge_i[0]);
        sec_ev_o <= (pclk_i != pc_q) && (pclk_i != (edge_i[0] ^ edge_i[1]));
        pri_o <= lvl[47:24];
        sec_o <= lvl[23:0];
    end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the pixel output formatter
`timescale 1ns/1ps
`include "pof_map.vh"
module tb_top;
    reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pix_valid_i = 0, chk = 0;
    reg pix_hs_i = 0, pix_vs_i = 0, pll_clk_i = 0;
    reg [7:0] adr_i = 0, pix_r_i = 0, pix_g_i = 0, pix_b_i = 0, seq = 0, fmt = 0, rd, a;
    reg [3:0] sel_i = 0;
    reg [31:0] dat_i = 0, v, u;
    reg [7:0] rmem [0:255];
    reg [7:0] bmem [0:255];
    wire [31:0] dat_o;
    wire ack_o, pix_ready_o, pocl, clk_oe_n_o, lso, fso, pll_pd_o, pev, sev;
    wire [7:0] rp, gp, bp, rs, gs, bs, tune;
    wire [5:0] oe_n;
    wire [2:0] adc_pd;
    wire [23:0] pri, sec;
    integer n_errors = 0, checked = 0, ticks = 0, i, t0;
    pof_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .pix_r_i(pix_r_i),
        .pix_g_i(pix_g_i), .pix_b_i(pix_b_i), .pix_hs_i(pix_hs_i), .pix_vs_i(pix_vs_i),
        .pll_clk_i(pll_clk_i), .rp_o(rp), .gp_o(gp), .bp_o(bp), .rs_o(rs), .gs_o(gs),
        .bs_o(bs), .byte_oe_n_o(oe_n), .pixel_output_clock_o(pocl), .clk_oe_n_o(clk_oe_n_o),
        .line_sync_output_o(lso), .frame_sync_output_o(fso), .adc_pd_o(adc_pd),
        .pll_pd_o(pll_pd_o), .pll_tune_o(tune));
    pof_rx RX (.clk_i(clk_i), .pins_i({rp, gp, bp, rs, gs, bs}), .oe_n_i(oe_n), .pclk_i(pocl),
        .edge_i({fmt[1], fmt[5]}), .pri_o(pri), .sec_o(sec), .pri_ev_o(pev), .sec_ev_o(sev));
    // pixel clock edges fall on a system clock edge once every 500 ns
    always #4 clk_i = ~clk_i;
    always #62.5 pll_clk_i = ~pll_clk_i;
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task cmp_px(input [23:0] got, input [23:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t pixel %h want %h", $time, got, exp);
            end
        end
    endtask
    task cmp_reg(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t value %h want %h", $time, got, exp);
            end
        end
    endtask
    // one classic cycle; waits for ack with no assumed latency
    task wb(input w, input [7:0] ad, input [7:0] d);
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= ad;
            sel_i <= 4'hF;
            dat_i <= {24'h000000, d};
            @(posedge clk_i);
            while (ack_o !== 1'b1)
                @(posedge clk_i);
            rd = dat_o[7:0];
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
        end
    endtask
    function [23:0] exp_px(input [23:0] w);
        reg [7:0] g;
        begin
            g = w[15:8];
            if (!fmt[4])
                exp_px = {rmem[g], g, bmem[g]};
            else if (!g[0])
                exp_px = {bmem[g], g, 8'h00};
            else
                exp_px = {rmem[fmt[3] ? g : g - 8'h01], g, 8'h00};
        end
    endfunction
    // source: green carries a sequence number, red and blue are random and recorded
    always @(posedge clk_i)
        if (pix_valid_i && pix_ready_o)
        begin
            u = $urandom;
            seq <= seq + 8'h01;
            pix_g_i <= seq + 8'h01;
            pix_r_i <= u[7:0];
            pix_b_i <= u[15:8];
            rmem[seq + 8'h01] = u[7:0];
            bmem[seq + 8'h01] = u[15:8];
            // source sync on pixel 31 of each group of 32, so the first pixel after the
            // line sync output ends (width 2 or 6) has an even sequence number
            pix_hs_i <= (seq[4:0] == 5'h1E);
        end
    // compare every captured word with the source record, secondaries with zero in 24-bit mode
    always @(posedge clk_i)
        if (chk)
        begin
            if (pev)
                cmp_px(pri, exp_px(pri));
            if (pev && fmt[0])
                cmp_reg({7'h00, pri[8]}, {7'h00, fmt[2]});
            if (sev)
                cmp_px(sec, fmt[0] ? exp_px(sec) : 24'h000000);
        end
    // hang guard
    always @(posedge clk_i)
    begin
        ticks = ticks + 1;
        if (ticks == 40000)
        begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        i = $urandom(32'h72C9E977);
        rmem[0] = 8'h00;
        bmem[0] = 8'h00;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        pix_valid_i <= 1'b1;
        a = `POF_ADR_FMT;
        for (i = 0; i < 6; i = i + 1)
        begin
            wb(1'b0, a, 8'h00);
            cmp_reg(rd, 48'h0049_0000_1000 >> (8 * i));
            a = a + 8'h04;
        end
        v = $urandom;
        wb(1'b1, `POF_ADR_PWR, v[7:0]);
        wb(1'b0, `POF_ADR_PWR, 8'h00);
        cmp_reg(rd, v[7:0] & `POF_PWR_MASK);
        cmp_reg({4'h0, pll_pd_o, adc_pd}, {4'h0, v[3:0]});
        wb(1'b1, `POF_ADR_PWR, 8'h00);
        wb(1'b1, `POF_ADR_PLL, 8'h4C);
        wb(1'b0, `POF_ADR_PLL, 8'h00);
        cmp_reg(rd, 8'h4C);
        cmp_reg(tune, 8'h4C);
        wb(1'b1, `POF_ADR_PLL, 8'h49);
        wb(1'b1, `POF_ADR_DIS, v[15:8]);
        repeat (2) @(posedge clk_i);
        cmp_reg({1'b0, clk_oe_n_o, oe_n}, {1'b0, |v[15:14], v[13:8]});
        wb(1'b1, `POF_ADR_DIS, 8'h00);
        $display("register test done");
        for (i = 0; i < 8; i = i + 1)
        begin
            chk = 1'b0;
            v = $urandom;
            a = 64'h0021_0307_2510_38C0 >> (8 * (7 - i));
            wb(1'b1, `POF_ADR_FMT, a);
            wb(1'b1, `POF_ADR_HSW, {5'h00, v[0], 2'h2});
            fmt = a;
            pix_vs_i <= v[1];
            repeat (150) @(posedge clk_i);
            chk = 1'b1;
            while (lso !== fmt[7])
                @(posedge clk_i);
            while (lso === fmt[7])
                @(posedge clk_i);
            t0 = $time;
            while (lso !== fmt[7])
                @(posedge clk_i);
            cmp_reg(($time - t0 + 62) / 125, {5'h00, v[0], 2'h2});
            cmp_reg({7'h00, fso}, {7'h00, v[1] ^ fmt[6]});
            repeat (300) @(posedge clk_i);
            $display("format %h test done", fmt);
        end
        print_verdict;
    end
endmodule
